/* core/mrsch_handler.sv */
// Serial command handler: request decode, register access and reply framing
//
// Contract
// RULE_01 - Every register moved over the link is a 16-bit unsigned word.
// RULE_02 - Functions 03 read, 06 write and 11 identify are accepted.
// RULE_03 - First frame byte must match the address switch; master keeps it unique.
// RULE_04 - Address, count and data fields travel high byte first.
// RULE_05 - Frames end in a 16-bit CRC sent low byte first.
// RULE_06 - Read request: address, 03, start, count, CRC low, CRC high.
// RULE_07 - Read reply: address, 03, byte count twice register count, values, CRC.
// RULE_08 - Read count must be 1 to 125; other counts are invalid.
// RULE_09 - Frame address is register number minus 40001, a zero-based offset.
// RULE_10 - Write request: address, 06, register, value, CRC low, CRC high.
// RULE_11 - Valid write is answered by an exact echo after the update.
// RULE_12 - Writing zero to offset zero clears the energy registers.
// RULE_13 - Write to an out-of-range first register returns an error reply.
// RULE_14 - Function 11 returns identifying information.
// RULE_15 - Example read at 37/000C carries CRC 41 9F, reply 70 40.
// RULE_16 - Identify reply: address, 11, count, id, run status, data, CRC.
// RULE_17 - Wrong address or bad CRC: frame discarded, nothing sent.
// RULE_18 - Error reply: address, function with bit 7, code 02, CRC. Unknown functions get code 01 (EXC_FUNC) here instead.
`timescale 1ns/1ps
module mrsch_handler (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  unit_addr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	input  wire logic        tx_ready,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	output logic             energy_clear,
	output logic             busy
);
	import mrsch_pkg::*;

	// ****************************************
	// State and storage
	// ****************************************
	mrsch_state_e     state;
	logic [7:0]       rxb [0:7];
	logic [3:0]       rx_cnt;
	logic [22:0]      gap;
	logic [7:0]       txb [0:7];
	logic [3:0]       tx_len;
	logic [3:0]       tx_idx;
	logic [15:0]      rd_left;
	logic [15:0]      rd_word;
	logic             rd_half;
	logic             rd_mode;
	logic [1:0]       crc_phase;
	logic             crc_clr;
	logic             crc_feed;
	logic [7:0]       crc_din;
	logic [15:0]      crc;

	// Field helpers, used for request decode
	function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo}; // [RULE_04]
	endfunction

	wire logic [7:0]  fn        = rxb[1];
	wire logic [15:0] f_addr    = be16(rxb[2], rxb[3]); // [RULE_09]
	wire logic [15:0] f_val     = be16(rxb[4], rxb[5]);
	wire logic [3:0]  need_len  = (fn == FN_IDENT) ? REQ_LEN_ID : REQ_LEN_RW;
	wire logic        frame_end = (gap == 23'(GAP_CYC)) && (rx_cnt != 4'h0);
	wire logic [15:0] last_reg  = f_addr + f_val - 16'h0001;
	wire logic        cnt_ok    = (f_val >= CNT_MIN) && (f_val <= CNT_MAX); // [RULE_08]
	wire logic        rd_rng_ok = (f_addr < REG_LIMIT) && (last_reg < REG_LIMIT);
	wire logic        wr_rng_ok = f_addr < REG_LIMIT; // [RULE_13]
	// Receive CRC runs over all bytes; residue zero means the trailer matched
	wire logic        crc_good  = (crc == 16'h0000); // [RULE_05]
	wire logic        addr_ok   = rxb[0] == unit_addr; // [RULE_03]
	wire logic        len_ok    = rx_cnt == need_len;
	wire logic        tx_fire   = tx_valid && tx_ready;
	wire logic        in_body   = tx_idx < tx_len;

	mrsch_crc u_crc (
		.mclk  (mclk),
		.rst   (rst),
		.clear (crc_clr),
		.feed  (crc_feed),
		.data  (crc_din),
		.crc   (crc)
	);

	// ****************************************
	// CRC feed selection
	// ****************************************
	// Same engine serves receive and transmit since the link is half duplex
	always_comb begin
		crc_clr  = (state == MRSCH_IDLE) && !rx_valid;
		crc_feed = 1'b0;
		crc_din  = rx_data;
		if ((state == MRSCH_IDLE || state == MRSCH_RECV) && rx_valid)
			crc_feed = 1'b1;
		else if (state == MRSCH_EXEC)
			crc_clr = 1'b1;
		else if ((state == MRSCH_SEND || state == MRSCH_RDREG) && tx_fire && crc_phase == 2'd0) begin
			crc_feed = 1'b1;
			crc_din  = tx_data;
		end
	end

	// ****************************************
	// Inter-frame gap timer
	// ****************************************
	// Silence of 3.5 characters closes the frame
	always_ff @(posedge mclk) begin
		if (rst || rx_valid)
			gap <= 23'h0;
		else if (gap != 23'(GAP_CYC))
			gap <= gap + 23'h1;
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state        <= MRSCH_IDLE;
			rx_cnt       <= 4'h0;
			tx_valid     <= 1'b0;
			tx_data      <= 8'h00;
			tx_len       <= 4'h0;
			tx_idx       <= 4'h0;
			reg_rd       <= 1'b0;
			reg_wr       <= 1'b0;
			reg_addr     <= 16'h0;
			reg_wdata    <= 16'h0;
			energy_clear <= 1'b0;
			busy         <= 1'b0;
			rd_left      <= 16'h0;
			rd_word      <= 16'h0;
			rd_half      <= 1'b0;
			rd_mode      <= 1'b0;
			crc_phase    <= 2'd0;
			for (int i = 0; i < 8; i++) begin
				rxb[i] <= 8'h00;
				txb[i] <= 8'h00;
			end
		end else begin
			reg_rd       <= 1'b0;
			reg_wr       <= 1'b0;
			energy_clear <= 1'b0;
			case (state)
				MRSCH_IDLE, MRSCH_RECV: begin
					busy <= 1'b0;
					if (rx_valid) begin
						state <= MRSCH_RECV;
						if (rx_cnt < 4'h8)
							rxb[rx_cnt[2:0]] <= rx_data;
						if (rx_cnt != 4'hf)
							rx_cnt <= rx_cnt + 4'h1;
					end else if (frame_end) begin
						rx_cnt <= 4'h0;
						busy   <= 1'b1;
						// Foreign or corrupt frames get no reply at all
						if (addr_ok && crc_good && len_ok)
							state <= MRSCH_EXEC;
						else
							state <= MRSCH_IDLE; // [RULE_17]
					end
				end
				MRSCH_EXEC: begin
					txb[0]    <= unit_addr;
					tx_idx    <= 4'h0;
					crc_phase <= 2'd0;
					rd_mode   <= 1'b0;
					state     <= MRSCH_SEND;
					case (fn)
						FN_READ: begin
							if (cnt_ok && rd_rng_ok) begin // [RULE_06]
								txb[1]   <= FN_READ;
								txb[2]   <= 8'(f_val << 1); // [RULE_07]
								tx_len   <= 4'h3;
								rd_left  <= f_val;
								reg_addr <= f_addr;
								reg_rd   <= 1'b1;
								rd_mode  <= 1'b1;
								state    <= MRSCH_RDREG;
							end else begin
								txb[1] <= FN_READ | EXC_FLAG; // [RULE_18]
								txb[2] <= EXC_ADDR;
								tx_len <= 4'h3;
							end
						end
						FN_WRITE: begin
							if (wr_rng_ok) begin // [RULE_10]
								reg_wr    <= 1'b1; // [RULE_01]
								reg_addr  <= f_addr;
								reg_wdata <= f_val;
								if (f_addr == ENERGY_REG && f_val == ENERGY_CLR)
									energy_clear <= 1'b1; // [RULE_12]
								// Echo includes the received CRC, so no recompute
								for (int i = 0; i < 8; i++)
									txb[i] <= rxb[i]; // [RULE_11]
								tx_len    <= 4'h8;
								crc_phase <= 2'd3;
							end else begin
								txb[1] <= FN_WRITE | EXC_FLAG; // [RULE_13]
								txb[2] <= EXC_ADDR; // [RULE_18]
								tx_len <= 4'h3;
							end
						end
						FN_IDENT: begin
							txb[1] <= FN_IDENT; // [RULE_14]
							txb[2] <= ID_COUNT; // [RULE_16]
							txb[3] <= ID_SLAVE;
							txb[4] <= ID_RUN;
							txb[5] <= ID_EXTRA0;
							txb[6] <= ID_EXTRA1;
							tx_len <= 4'h7;
						end
						default: begin
							txb[1] <= fn | EXC_FLAG; // [RULE_02]
							txb[2] <= EXC_FUNC;
							tx_len <= 4'h3;
						end
					endcase
				end
				MRSCH_RDREG: begin
					// One cycle of read latency from the register bank
					rd_word <= reg_rdata; // [RULE_01]
					rd_half <= 1'b0;
					state   <= MRSCH_SEND;
					// A byte taken here must not be offered twice
					if (tx_fire)
						tx_valid <= 1'b0;
				end
				MRSCH_SEND: begin
					if (!tx_valid || tx_fire) begin
						if (tx_fire && crc_phase == 2'd2) begin
							tx_valid <= 1'b0;
							state    <= MRSCH_IDLE;
						end else if (in_body) begin
							tx_valid <= 1'b1;
							tx_data  <= txb[tx_idx[2:0]];
							tx_idx   <= tx_idx + 4'h1;
							if (crc_phase == 2'd3 && tx_idx == 4'h7)
								crc_phase <= 2'd2;
						end else if (rd_mode && rd_left != 16'h0) begin
							// Values go out high byte first
							tx_valid <= 1'b1;
							tx_data  <= rd_half ? rd_word[7:0] : rd_word[15:8]; // [RULE_04]
							rd_half  <= !rd_half;
							if (rd_half) begin
								rd_left  <= rd_left - 16'h1;
								if (rd_left != 16'h1) begin
									reg_addr <= reg_addr + 16'h1;
									reg_rd   <= 1'b1;
									state    <= MRSCH_RDREG;
								end
							end
						end else if (crc_phase == 2'd0) begin
							// One quiet cycle lets the last body byte settle into the sum
							tx_valid  <= 1'b0;
							crc_phase <= 2'd1;
						end else if (tx_idx == tx_len) begin
							// CRC trailer: low byte first
							tx_valid <= 1'b1;
							tx_data  <= crc[7:0]; // [RULE_05]
							tx_idx   <= tx_idx + 4'h1;
						end else begin
							tx_valid  <= 1'b1;
							tx_data   <= crc[15:8]; // [RULE_15]
							crc_phase <= 2'd2;
						end
					end
				end
				MRSCH_DROP: state <= MRSCH_IDLE;
				default:    state <= MRSCH_IDLE;
			endcase
		end
	end
endmodule // mrsch_handler

/* core/mrsch_pkg.sv */
// Package of constants for the serial command handler
package mrsch_pkg;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam logic [7:0] FN_READ      = 8'h03;
	localparam logic [7:0] FN_WRITE     = 8'h06;
	localparam logic [7:0] FN_IDENT     = 8'h11;
	localparam logic [7:0] EXC_FLAG     = 8'h80;
	localparam logic [7:0] EXC_ADDR     = 8'h02;
	localparam logic [7:0] EXC_FUNC     = 8'h01;
	localparam logic [3:0] REQ_LEN_RW   = 4'h8;
	localparam logic [3:0] REQ_LEN_ID   = 4'h4;
	localparam logic [15:0] CNT_MIN     = 16'h0001;
	localparam logic [15:0] CNT_MAX     = 16'h007d;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] REG_LIMIT   = 16'h2000;
	localparam logic [15:0] ENERGY_REG  = 16'h0000;
	localparam logic [15:0] ENERGY_CLR  = 16'h0000;
	// ****************************************
	// Identification data, values arbitrary
	// ****************************************
	localparam logic [7:0] ID_COUNT     = 8'h04;
	localparam logic [7:0] ID_SLAVE     = 8'h5a;
	localparam logic [7:0] ID_RUN       = 8'hff;
	localparam logic [7:0] ID_EXTRA0    = 8'h01;
	localparam logic [7:0] ID_EXTRA1    = 8'h02;
	// ****************************************
	// CRC
	// ****************************************
	localparam logic [15:0] CRC_INIT    = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'ha001;
	localparam int          CRC_BITS    = 8;
	// ****************************************
	// Gap timeout: 3.5 chars at 9600 baud
	// ****************************************
	localparam int          CLK_HZ      = 10_000_000;
	localparam int          GAP_US      = 4010;
	localparam int          GAP_CYC     = (CLK_HZ / 1_000_000) * GAP_US;
	typedef enum logic [2:0] {
		MRSCH_IDLE, MRSCH_RECV, MRSCH_EXEC, MRSCH_RDREG, MRSCH_SEND, MRSCH_DROP
	} mrsch_state_e;
endpackage

/* core/mrsch_crc.sv */
// Byte-wise CRC-16 accumulator for the serial link
`timescale 1ns/1ps
module mrsch_crc (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        feed,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc
);
	import mrsch_pkg::*;

	// Eight shift steps unrolled by loop; one byte per cycle
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < CRC_BITS; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	wire logic [15:0] next_crc = crc_step(crc, data);

	// Clear takes priority so a new frame never inherits old state
	always_ff @(posedge mclk) begin
		if (rst || clear)
			crc <= CRC_INIT;
		else if (feed)
			crc <= next_crc; // [RULE_05]
	end
endmodule // mrsch_crc

/* verif/mrsch_handler_props.sv */
// Port-level checker for the serial command handler
`timescale 1ns/1ps
module mrsch_handler_props
	import mrsch_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  unit_addr,
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_data,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        energy_clear,
	input wire logic        busy
);
	logic [15:0] idle;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Quiet cycles since the last received byte; saturates so it never wraps
	always_ff @(posedge mclk) begin
		if (rst || rx_valid) idle <= 16'h0000;
		else if (idle != 16'hffff) idle <= idle + 16'h0001;
	end
	clear_qual_a: assert property (energy_clear |-> reg_wr && reg_addr == ENERGY_REG
		&& reg_wdata == ENERGY_CLR) else $error("energy clear without zero write");
	wr_range_a: assert property (reg_wr |-> reg_addr < REG_LIMIT)
		else $error("write outside register range");
	rd_range_a: assert property (reg_rd |-> reg_addr < REG_LIMIT)
		else $error("read outside register range");
	rd_pulse_a: assert property (reg_rd |=> !reg_rd) else $error("read strobe too long");
	wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("write strobe too long");
	no_rdwr_a: assert property (!(reg_rd && reg_wr)) else $error("read and write together");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("offered byte dropped or changed");
	reply_gap_a: assert property ($rose(tx_valid) |-> idle >= 16'(GAP_CYC))
		else $error("reply before frame closed");
	cover property (reg_rd);
	cover property (reg_wr && energy_clear);
	cover property (tx_valid && tx_ready);
endmodule // mrsch_handler_props

bind mrsch_handler mrsch_handler_props chk (.mclk(mclk), .rst(rst), .unit_addr(unit_addr),
	.rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .energy_clear(energy_clear), .busy(busy));

/* verif/mrsch_master_model.sv */
// Behavioural serial master on the far side of the handler
`timescale 1ns/1ps
module mrsch_master_model (
	input  wire logic       mclk,
	input  wire logic       slow,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] got[$];
	logic       ph;
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
		ph       = 1'b0;
	end
	// Slow mode takes a byte only every other cycle to stress the hold
	always @(negedge mclk) begin
		ph       = ~ph;
		tx_ready = !slow || ph;
	end
	always @(posedge mclk) if (tx_valid && tx_ready) got.push_back(tx_data);
	// One byte per call, fields already ordered by the caller
	task send(input logic [7:0] b);
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_data  = b;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data  = ~b; // Released line shows no stale byte
	endtask
endmodule // mrsch_master_model

/* verif/testbench.sv */
// Self-checking bench: documented read and energy-clear write frames
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin $display("mismatch %s exp %h got %h", n, e, s); n_mismatch++; end end
module testbench;
	import mrsch_pkg::*;
	logic        mclk, rst, slow, rx_valid, tx_valid, tx_ready, reg_rd, reg_wr;
	logic        energy_clear, busy;
	logic [7:0]  unit_addr, rx_data, tx_data;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_seen, wr_addr, wr_data;
	int          n_mismatch, n_tests, n_clear;
	// Register bank stand-in: reads zero only at offset 0C, so a wrong offset shows
	assign reg_rdata = reg_addr ^ 16'h000c;
	mrsch_handler dut (.mclk(mclk), .rst(rst), .unit_addr(unit_addr), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .energy_clear(energy_clear), .busy(busy));
	mrsch_master_model master (.mclk(mclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Record register side effects as they happen
	always @(posedge mclk) begin
		if (reg_rd) rd_seen <= reg_addr;
		if (reg_wr) begin
			wr_addr <= reg_addr;
			wr_data <= reg_wdata;
		end
		if (energy_clear) n_clear++;
	end
	// ****************************************
	// Shared frame exchange
	// ****************************************
	task xfer(input logic [7:0] req[$], input logic [7:0] exp[$]);
		int i;
		master.got.delete();
		foreach (req[k]) master.send(req[k]);
		i = 0;
		while (master.got.size() < exp.size() && i < 41000) begin
			@(negedge mclk);
			i++;
		end
		`CHK("reply length", exp.size(), master.got.size())
		foreach (exp[k]) if (k < master.got.size()) `CHK("reply byte", exp[k], master.got[k])
	endtask
	task read_example;
		slow = 1'b0;
		rd_seen = 16'hffff;
		xfer('{8'h37, 8'h03, 8'h00, 8'h0c, 8'h00, 8'h01, 8'h41, 8'h9f},
			'{8'h37, 8'h03, 8'h02, 8'h00, 8'h00, 8'h70, 8'h40});
		`CHK("read offset", 16'h000c, rd_seen)
	endtask
	task write_clear;
		slow = 1'b1;
		n_clear = 0;
		wr_addr = 16'hffff;
		wr_data = 16'hffff;
		xfer('{8'h37, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8c, 8'h5c},
			'{8'h37, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8c, 8'h5c});
		`CHK("write offset", 16'h0000, wr_addr)
		`CHK("write value", 16'h0000, wr_data)
		`CHK("energy clears", 1, n_clear)
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		slow = 1'b0;
		unit_addr = 8'h37;
		n_mismatch = 0;
		n_tests = 0;
		n_clear = 0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		read_example;
		@(negedge mclk);
		write_clear;
		tally_and_finish;
	end
	// Two frames each need a full quiet gap; allow a margin beyond that
	initial begin
		#(100.0 * 90000);
		n_mismatch++;
		tally_and_finish;
	end
endmodule // testbench
